/* File: common/gauge_calibration_map.svh */
/*
 holds the calibration byte locations, bus register offsets, reset values and decode constants.
 assumes inclusion by bare name from the package and the design files.
*/
`ifndef GAUGE_CALIBRATION_MAP_SVH
`define GAUGE_CALIBRATION_MAP_SVH

// configuration memory window
`define CAL_BASE_ADDR 7'h12
`define CAL_LAST_ADDR 7'h1E
`define CAL_BYTES 13

// index of each byte inside the window
`define CAL_IDX_TEMP_OFF 4'h0
`define CAL_IDX_MAX_TEMP 4'h1
`define CAL_IDX_SELF_DIS 4'h2
`define CAL_IDX_FILTER 4'h3
`define CAL_IDX_CGAIN_LO 4'h4
`define CAL_IDX_CGAIN_HI 4'h5
`define CAL_IDX_FULL_PCT 4'h6
`define CAL_IDX_CHG_COMP 4'h7
`define CAL_IDX_VOFF 4'h8
`define CAL_IDX_VGAIN_INT 4'h9
`define CAL_IDX_VGAIN_FRAC 4'hA
`define CAL_IDX_SER_LO 4'hB
`define CAL_IDX_SER_HI 4'hC

// reset values
`define CAL_TEMP_OFF_RST 8'h80

// decode constants, temperatures in 0.1 degree units
`define CAL_MAX_TEMP_BASE 10'h2E4
`define CAL_STEP_BASE 6'h10
`define CAL_MAINT_BASE 8'h80
`define CAL_FAST_BASE 8'hC0
`define CAL_VGAIN_FRAC_BITS 8

// bus register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TEMP 8'h08
`define REG_CHG_TEMP 8'h0C
`define REG_SELF_DIS 8'h10
`define REG_CUR_GAIN 8'h14
`define REG_FULL_PCT 8'h18
`define REG_EFF 8'h1C
`define REG_VOLT 8'h20
`define REG_SERIAL 8'h24

// field positions
`define CTRL_RELOAD_BIT 0
`define STATUS_VALID_BIT 0
`define STATUS_BUSY_BIT 1

`endif

/* File: common/gauge_calibration_pkg.sv */
/*
 holds the state types of the calibration decoder.
 assumes the map header sits beside it on the include path.
*/
`include "gauge_calibration_map.svh"

package gauge_calibration_pkg;

	typedef enum logic [1:0] {
		walk_idle,
		walk_addr,
		walk_take
	} walk_state_t;

	typedef struct packed {
		walk_state_t st;
		logic [3:0] idx;
		logic [`CAL_BYTES-1:0][7:0] hold;
		logic valid;
		logic ack;
		logic [31:0] rdata;
		logic [12:0] temp;
		logic [9:0] max_temp;
		logic [5:0] step;
		logic [7:0] sd_div;
		logic [7:0] filt;
		logic [15:0] cur_gain;
		logic [15:0] vgain;
		logic [7:0] full_pct;
		logic [7:0] maint_eff;
		logic [7:0] fast_eff;
		logic [15:0] serial;
		logic [15:0] sense_f;
		logic [16:0] vsum;
		logic rc_set;
		logic [7:0] rc_value;
	} core_state_t;

endpackage

/* File: logic/cal_byte_store.sv */
/*
 small byte memory holding the raw calibration window; read data leave a register.
 assumes one write and one read port, both on core_clk.
*/
module cal_byte_store #(
	parameter int DEPTH = 13,
	parameter int AW = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0] rd;
	} store_state_t;

	store_state_t s_q;
	store_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			s_d.mem[wr_addr] = wr_data;
		end
		s_d.rd = (int'(rd_addr) < DEPTH) ? s_q.mem[rd_addr] : 8'h00;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.rd;
endmodule // cal_byte_store

/* File: logic/cal_scale_mult.sv */
/*
 registered unsigned scaler: product of two operands shifted right by a fixed amount.
 assumes operands stable for one cycle; result appears one edge later.
*/
module cal_scale_mult #(
	parameter int AW = 17,
	parameter int BW = 16,
	parameter int SHIFT = 8,
	parameter int OW = 24
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [AW-1:0] op_a,
	input wire logic [BW-1:0] op_b,
	output logic [OW-1:0] result
);
	typedef struct packed {
		logic [OW-1:0] p;
	} mult_state_t;

	mult_state_t s_q;
	mult_state_t s_d;
	logic [AW+BW-1:0] full;

	always_comb begin
		full = op_a * op_b;
		s_d.p = OW'(full >> SHIFT);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign result = s_q.p;
endmodule // cal_scale_mult

/* File: logic/gauge_calibration_decode.sv */
/*
 calibration decoder: stores the configuration bytes, latches them after each load,
 decodes them into working values and applies them to temperature, current and voltage.
 assumes an eeprom reader delivers bytes with their addresses and a done pulse.
*/
// Decided for this implementation: the Wishbone slave port and the address map.
`include "gauge_calibration_map.svh"

module gauge_calibration_decode
	import gauge_calibration_pkg::*;
#(
	parameter int CUR_SHIFT = 8
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_wdata,
	output logic [31:0] wb_rdata,
	output logic wb_ack,
	input wire logic cfg_we,
	input wire logic [6:0] cfg_addr,
	input wire logic [7:0] cfg_data,
	input wire logic cfg_done,
	input wire logic [11:0] raw_temp,
	input wire logic [15:0] sense_resistor_input,
	input wire logic [15:0] battery_sense_voltage,
	input wire logic full_term,
	input wire logic [7:0] remaining_capacity_value,
	output logic cal_valid,
	output logic [12:0] corrected_temp,
	output logic [9:0] max_charge_temp,
	output logic [5:0] temp_step,
	output logic [7:0] self_dis_divisor,
	output logic [7:0] filter_threshold,
	output logic [15:0] current_gain,
	output logic [23:0] current_scaled,
	output logic [7:0] full_charge_pct,
	output logic rc_raise,
	output logic [7:0] rc_raise_value,
	output logic [7:0] maint_eff,
	output logic [7:0] fast_eff,
	output logic [23:0] voltage_out,
	output logic [15:0] pack_serial
);
	core_state_t s_q;
	core_state_t s_d;
	logic [7:0] rd_byte;
	logic [6:0] cfg_rel;
	logic cfg_hit;
	logic bus_req;
	logic wr_fire;
	logic load_start;
	logic [7:0] hb [`CAL_BYTES];

	assign cfg_rel = cfg_addr - `CAL_BASE_ADDR;
	assign cfg_hit = cfg_we && (cfg_addr >= `CAL_BASE_ADDR) && (cfg_addr <= `CAL_LAST_ADDR);

	cal_byte_store #(
		.DEPTH(`CAL_BYTES),
		.AW(4)
	) u_store (
		.core_clk(core_clk),
		.nrst(nrst),
		.wr_en(cfg_hit),
		.wr_addr(cfg_rel[3:0]),
		.wr_data(cfg_data),
		.rd_addr(s_q.idx),
		.rd_data(rd_byte)
	);

	// voltage scaling by 8.8 gain
	cal_scale_mult #(
		.AW(17),
		.BW(16),
		.SHIFT(`CAL_VGAIN_FRAC_BITS),
		.OW(24)
	) u_volt (
		.core_clk(core_clk),
		.nrst(nrst),
		.op_a(s_q.vsum),
		.op_b(s_q.vgain),
		.result(voltage_out)
	);

	// current scaling by integration gain
	cal_scale_mult #(
		.AW(16),
		.BW(16),
		.SHIFT(CUR_SHIFT),
		.OW(24)
	) u_cur (
		.core_clk(core_clk),
		.nrst(nrst),
		.op_a(s_q.sense_f),
		.op_b(s_q.cur_gain),
		.result(current_scaled)
	);

	genvar gi;
	generate
		for (gi = 0; gi < `CAL_BYTES; gi++) begin : g_hold
			assign hb[gi] = s_q.hold[gi];
		end
	endgenerate

	assign bus_req = wb_cyc && wb_stb;
	assign wr_fire = bus_req && wb_we && s_q.ack;
	assign load_start = cfg_done || (wr_fire && wb_sel[0] && (wb_adr == `REG_CTRL)
		&& wb_wdata[`CTRL_RELOAD_BIT]);

	always_comb begin
		s_d = s_q;
		// load walk: copy stored bytes into holding registers
		unique case (s_q.st)
			walk_idle: begin
				if (load_start) begin
					s_d.st = walk_addr;
					s_d.idx = 4'h0;
					s_d.valid = 1'b0;
				end
			end
			walk_addr: begin
				s_d.st = walk_take;
			end
			walk_take: begin
				s_d.hold[s_q.idx] = rd_byte;
				if (s_q.idx == 4'(`CAL_BYTES - 1)) begin
					s_d.st = walk_idle;
					s_d.valid = 1'b1;
				end else begin
					s_d.idx = s_q.idx + 4'h1;
					s_d.st = walk_addr;
				end
			end
		endcase
		// decode of held bytes
		s_d.temp = {1'b0, raw_temp} + {5'h00, hb[`CAL_IDX_TEMP_OFF]};
		s_d.max_temp = `CAL_MAX_TEMP_BASE - {2'h0, hb[`CAL_IDX_MAX_TEMP][7:4], 4'h0};
		s_d.step = {1'b0, hb[`CAL_IDX_MAX_TEMP][3:0], 1'b0} + `CAL_STEP_BASE;
		s_d.sd_div = 8'h00 - hb[`CAL_IDX_SELF_DIS];
		s_d.filt = hb[`CAL_IDX_FILTER];
		s_d.cur_gain = {hb[`CAL_IDX_CGAIN_HI], hb[`CAL_IDX_CGAIN_LO]};
		s_d.full_pct = 8'h00 - hb[`CAL_IDX_FULL_PCT];
		s_d.maint_eff = {1'b0, hb[`CAL_IDX_CHG_COMP][7:4], 3'h0} + `CAL_MAINT_BASE;
		s_d.fast_eff = {2'h0, hb[`CAL_IDX_CHG_COMP][3:0], 2'h0} + `CAL_FAST_BASE;
		s_d.vgain = {hb[`CAL_IDX_VGAIN_INT], hb[`CAL_IDX_VGAIN_FRAC]};
		s_d.serial = {hb[`CAL_IDX_SER_HI], hb[`CAL_IDX_SER_LO]};
		s_d.vsum = {1'b0, battery_sense_voltage} + {9'h000, hb[`CAL_IDX_VOFF]};
		s_d.sense_f = (sense_resistor_input < {8'h00, s_q.filt}) ? 16'h0000
			: sense_resistor_input;
		// full charge termination
		s_d.rc_set = 1'b0;
		if (full_term && (remaining_capacity_value < s_q.full_pct)) begin
			s_d.rc_set = 1'b1;
			s_d.rc_value = s_q.full_pct;
		end
		// wishbone slave, one ack per request
		s_d.ack = bus_req && !s_q.ack;
		s_d.rdata = 32'h0000_0000;
		if (bus_req && !s_q.ack && !wb_we) begin
			unique case (wb_adr)
				`REG_STATUS: begin
					s_d.rdata[`STATUS_VALID_BIT] = s_q.valid;
					s_d.rdata[`STATUS_BUSY_BIT] = (s_q.st != walk_idle);
				end
				`REG_TEMP: s_d.rdata = {19'h00000, s_q.temp};
				`REG_CHG_TEMP: s_d.rdata = {10'h000, s_q.step, 6'h00, s_q.max_temp};
				`REG_SELF_DIS: s_d.rdata = {16'h0000, s_q.filt, s_q.sd_div};
				`REG_CUR_GAIN: s_d.rdata = {s_q.vgain, s_q.cur_gain};
				`REG_FULL_PCT: s_d.rdata = {24'h000000, s_q.full_pct};
				`REG_EFF: s_d.rdata = {16'h0000, s_q.fast_eff, s_q.maint_eff};
				`REG_VOLT: s_d.rdata = {8'h00, voltage_out};
				`REG_SERIAL: s_d.rdata = {16'h0000, s_q.serial};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.hold[`CAL_IDX_TEMP_OFF] <= `CAL_TEMP_OFF_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_ack = s_q.ack;
	assign wb_rdata = s_q.rdata;
	assign cal_valid = s_q.valid;
	assign corrected_temp = s_q.temp;
	assign max_charge_temp = s_q.max_temp;
	assign temp_step = s_q.step;
	assign self_dis_divisor = s_q.sd_div;
	assign filter_threshold = s_q.filt;
	assign current_gain = s_q.cur_gain;
	assign full_charge_pct = s_q.full_pct;
	assign rc_raise = s_q.rc_set;
	assign rc_raise_value = s_q.rc_value;
	assign maint_eff = s_q.maint_eff;
	assign fast_eff = s_q.fast_eff;
	assign pack_serial = s_q.serial;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence walk_begin_s;
		(s_q.st == walk_idle) && load_start;
	endsequence

	sequence walk_end_s;
		(!cal_valid) [*8] ##[1:30] cal_valid;
	endsequence

	bus_ack_pulse_a: assert property (wb_ack |=> !wb_ack)
		else $error("ack held for more than one cycle");
	temp_offset_a: assert property ($past(nrst) |-> corrected_temp == $past(raw_temp)
		+ $past(hb[`CAL_IDX_TEMP_OFF]))
		else $error("temperature not corrected by offset");
	max_temp_a: assert property ($past(nrst) |-> max_charge_temp == 10'd740
		- 10'(16 * $past(hb[`CAL_IDX_MAX_TEMP][7:4])))
		else $error("maximum charge temperature wrong");
	step_decode_a: assert property ($past(nrst) |-> temp_step
		== 6'(2 * $past(hb[`CAL_IDX_MAX_TEMP][3:0]) + 16))
		else $error("temperature step wrong");
	self_dis_a: assert property ($past(nrst) |->
		8'(self_dis_divisor + $past(hb[`CAL_IDX_SELF_DIS])) == 8'h00)
		else $error("self-discharge divisor not negated byte");
	filter_copy_a: assert property ($past(nrst) |-> filter_threshold
		== $past(hb[`CAL_IDX_FILTER]))
		else $error("filter threshold not taken from byte");
	cur_gain_a: assert property ($past(nrst) |-> current_gain == {$past(hb[`CAL_IDX_CGAIN_HI]),
		$past(hb[`CAL_IDX_CGAIN_LO])})
		else $error("current gain byte order wrong");
	filter_pass_a: assert property ((sense_resistor_input >= {8'h00, s_q.filt})
		|=> ##1 (current_scaled == 24'((32'($past(sense_resistor_input, 2))
		* $past(s_q.cur_gain)) >> CUR_SHIFT)))
		else $error("sense reading not scaled by gain");
	full_pct_a: assert property ($past(nrst) |->
		8'(full_charge_pct + $past(hb[`CAL_IDX_FULL_PCT])) == 8'h00)
		else $error("full charge percentage not negated byte");
	vgain_pack_a: assert property ($past(nrst) |-> s_q.vgain == {$past(hb[`CAL_IDX_VGAIN_INT]),
		$past(hb[`CAL_IDX_VGAIN_FRAC])})
		else $error("voltage gain packing wrong");
	hold_steady_a: assert property ((s_q.st == walk_idle) && !load_start
		|=> $stable(s_q.hold))
		else $error("held bytes changed outside a load");
	serial_read_a: assert property (bus_req && !wb_ack && !wb_we && (wb_adr == `REG_SERIAL)
		|=> wb_ack && (wb_rdata == {16'h0000, $past(pack_serial)}))
		else $error("serial register read wrong");
	filter_reject_a: assert property ((sense_resistor_input < {8'h00, s_q.filt})
		|=> ##1 (current_scaled == 24'h000000))
		else $error("small sense reading not rejected");
	full_raise_a: assert property (full_term && (remaining_capacity_value < full_charge_pct)
		|=> rc_raise && (rc_raise_value == $past(full_charge_pct)))
		else $error("capacity not raised to full percentage");
	full_keep_a: assert property (!(full_term && (remaining_capacity_value < full_charge_pct))
		|=> !rc_raise)
		else $error("capacity raised when not lower");
	eff_decode_a: assert property ($past(nrst) |->
		(maint_eff == 8'(128 + 8 * $past(hb[`CAL_IDX_CHG_COMP][7:4])))
		&& (fast_eff == 8'(192 + 4 * $past(hb[`CAL_IDX_CHG_COMP][3:0]))))
		else $error("charge efficiency decode wrong");
	serial_pair_a: assert property ($past(nrst) |-> pack_serial == {$past(hb[`CAL_IDX_SER_HI]),
		$past(hb[`CAL_IDX_SER_LO])})
		else $error("serial number byte order wrong");
	volt_scale_a: assert property ($past(nrst) |-> voltage_out == 24'((33'($past(s_q.vsum))
		* $past(s_q.vgain)) >> 8))
		else $error("voltage scaling wrong");
	load_walk_a: assert property (walk_begin_s |=> walk_end_s)
		else $error("load walk did not finish in time");
endmodule // gauge_calibration_decode

/* File: tb/cal_eeprom_model.sv */
/*
 model of the configuration memory reader: streams the calibration bytes with their addresses.
 assumes go is a one-cycle pulse on core_clk; image index 0 belongs to address 0x12.
*/
module cal_eeprom_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic go,
	input wire logic with_done,
	input wire logic [12:0][7:0] image,
	output logic cfg_we,
	output logic [6:0] cfg_addr,
	output logic [7:0] cfg_data,
	output logic cfg_done,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] pos_q;
	logic run_q;
	assign busy = run_q;
	// one byte every second cycle, 0x11 to 0x1f; the two outer bytes lie outside the window
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			run_q <= 1'b0;
			pos_q <= 5'h00;
			cfg_we <= 1'b0;
			cfg_done <= 1'b0;
			cfg_addr <= 7'h00;
			cfg_data <= 8'h00;
		end else begin
			cfg_we <= 1'b0;
			cfg_done <= 1'b0;
			cfg_data <= ~cfg_data;
			if (go && !run_q) begin
				run_q <= 1'b1;
				pos_q <= 5'h00;
			end else if (run_q) begin
				pos_q <= pos_q + 5'h01;
				if (!pos_q[0] && pos_q < 5'h1E) begin
					cfg_we <= 1'b1;
					cfg_addr <= 7'h11 + {3'h0, pos_q[4:1]};
					if (pos_q[4:1] == 4'h0 || pos_q[4:1] == 4'hE) begin
						cfg_data <= 8'h5A;
					end else begin
						cfg_data <= image[pos_q[4:1] - 4'h1];
					end
				end
				if (pos_q == 5'h1E) begin
					cfg_done <= with_done;
					run_q <= 1'b0;
				end
			end
		end
	end
endmodule // cal_eeprom_model

/* File: tb/test_gauge_calibration_decode.sv */
/*
 testbench of the calibration decoder: loads images, reads registers, checks every decoded value.
 assumes the eeprom model and the design files are compiled before it.
*/
`include "gauge_calibration_map.svh"
module test_gauge_calibration_decode;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, nrst = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, full_term = 1'b0;
	logic go = 1'b0, with_done = 1'b0, busy, cfg_we, cfg_done, wb_ack, cal_valid, rc_raise;
	logic [7:0] wb_adr = 8'h00, remaining_capacity_value = 8'h00, cfg_data;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdata = 32'h0, wb_rdata, rd;
	logic [6:0] cfg_addr;
	logic [11:0] raw_temp = 12'd200;
	logic [15:0] sense_resistor_input = 16'h0, battery_sense_voltage = 16'd10000;
	logic [12:0] corrected_temp;
	logic [9:0] max_charge_temp;
	logic [5:0] temp_step;
	logic [7:0] self_dis_divisor, filter_threshold, full_charge_pct, rc_raise_value;
	logic [7:0] maint_eff, fast_eff;
	logic [15:0] current_gain, pack_serial;
	logic [23:0] current_scaled, voltage_out;
	logic [12:0][7:0] img, e;
	int mismatches = 0, checks = 0, cyc_n = 0;

	cal_eeprom_model part_u (.core_clk, .nrst, .go, .with_done, .image(img), .cfg_we, .cfg_addr,
		.cfg_data, .cfg_done, .busy);
	gauge_calibration_decode #(.CUR_SHIFT(8)) dut_u (.core_clk, .nrst, .wb_cyc, .wb_stb, .wb_we,
		.wb_adr, .wb_sel, .wb_wdata, .wb_rdata, .wb_ack, .cfg_we, .cfg_addr, .cfg_data, .cfg_done,
		.raw_temp, .sense_resistor_input, .battery_sense_voltage, .full_term,
		.remaining_capacity_value, .cal_valid, .corrected_temp, .max_charge_temp, .temp_step,
		.self_dis_divisor, .filter_threshold, .current_gain, .current_scaled, .full_charge_pct,
		.rc_raise, .rc_raise_value, .maint_eff, .fast_eff, .voltage_out, .pack_serial);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hF;
		wb_wdata <= wd;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		rd = wb_rdata;
		check("ack", wb_ack, 32'h1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wait_valid();
		int n;
		n = 0;
		repeat (2) @(posedge core_clk);
		while (cal_valid !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		repeat (2) @(posedge core_clk);
	endtask
	task automatic load(input logic done);
		with_done <= done;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (2) @(posedge core_clk);
		while (busy === 1'b1) @(posedge core_clk);
		if (done) wait_valid();
	endtask
	task automatic check_all();
		check("temp", corrected_temp, 13'(raw_temp) + 13'(e[0]));
		check("max", max_charge_temp, 10'd740 - 10'(16 * e[1][7:4]));
		check("step", temp_step, 6'(e[1][3:0] * 2 + 16));
		check("sdis", self_dis_divisor, 8'(8'h00 - e[2]));
		check("filt", filter_threshold, e[3]);
		check("cgain", current_gain, {e[5], e[4]});
		check("pct", full_charge_pct, 8'(8'h00 - e[6]));
		check("maint", maint_eff, 8'(e[7][7:4] * 8 + 128));
		check("fast", fast_eff, 8'(e[7][3:0] * 4 + 192));
		check("volt", voltage_out, 24'(((32'(battery_sense_voltage) + e[8]) * {e[9], e[10]}) >> 8));
		check("serial", pack_serial, {e[12], e[11]});
	endtask
	task automatic sense(input logic [15:0] v);
		sense_resistor_input <= v;
		repeat (4) @(posedge core_clk);
		check("cur", current_scaled, v < e[3] ? 32'h0 : (32'(v) * {e[5], e[4]}) >> 8);
	endtask
	task automatic term(input logic [7:0] rc, input logic exp);
		remaining_capacity_value <= rc;
		full_term <= 1'b1;
		@(posedge core_clk);
		full_term <= 1'b0;
		@(posedge core_clk);
		check("raise", rc_raise, exp);
		if (exp) check("rval", rc_raise_value, 8'(8'h00 - e[6]));
		@(posedge core_clk);
	endtask

	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		e = '0;
		e[0] = 8'h80;
		img = 104'h2712_1709_0ABD_A000_4096_DD87_32;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		check("valid", cal_valid, 32'h0);
		check_all();
		load(1'b1);
		e = img;
		check_all();
		wb_cycle(1'b0, `REG_CHG_TEMP, 32'h0);
		check("chg_reg", rd, {10'h0, 6'(e[1][3:0] * 2 + 16), 6'h0, 10'd740 - 10'(16 * e[1][7:4])});
		wb_cycle(1'b0, `REG_SERIAL, 32'h0);
		check("ser_reg", rd, {16'h0, e[12], e[11]});
		wb_cycle(1'b0, `REG_STATUS, 32'h0);
		check("status", rd, 32'h1);
		wb_cycle(1'b0, 8'h40, 32'h0);
		check("unmapped", rd, 32'h0);
		sense(16'h0095);
		sense(16'h0096);
		sense(16'h1234);
		term(8'h50, 1'b1);
		term(8'h70, 1'b0);
		img[12:11] = 16'h1234;
		img[0] = 8'h05;
		load(1'b0);
		check_all();
		wb_cycle(1'b1, `REG_CTRL, 32'h1);
		wait_valid();
		e = img;
		check_all();
		conclude();
	end
endmodule // test_gauge_calibration_decode
